/* File: rtl/ctc_pkg.sv */
`default_nettype none
package ctc_pkg;
   // One received code-group: control flag and octet
   typedef struct packed {
      logic       k;
      logic [7:0] d;
   } cg_t;
   localparam int CG_W = 9;

   // Register byte offsets
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] THRESH_OFS = 12'h004;
   localparam logic [11:0] STATUS_OFS = 12'h008;
   localparam logic [11:0] ACTIVE_OFS = 12'h00C;
   localparam logic [11:0] COUNT_OFS  = 12'h010;

   // Control, status and threshold field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_STYLE    = 2;
   localparam int CTRL_RATE_LSB = 4;
   localparam int CTRL_ENABLE   = 8;
   localparam int STAT_OVF      = 16;
   localparam int THR_HIGH_LSB  = 16;

   // Compensation modes and port styles
   localparam logic [1:0] MODE_DYNAMIC = 2'h0;
   localparam logic [1:0] MODE_STATIC  = 2'h1;
   localparam logic [1:0] MODE_NONE    = 2'h2;
   localparam logic       STYLE_CLASSIC = 1'b0;
   localparam logic       STYLE_SINGLE  = 1'b1;

   // Operating rate codes
   localparam logic [1:0] RATE_1G   = 2'h2;
   localparam logic [1:0] RATE_100M = 2'h1;
   localparam logic [1:0] RATE_10M  = 2'h0;

   // Reset values and threshold limits
   localparam logic [31:0] CTRL_RST = 32'h0000_0120;
   localparam logic [9:0]  LOW_RST  = 10'h010;
   localparam logic [9:0]  HIGH_RST = 10'h020;
   localparam logic [9:0]  LOW_MIN  = 10'h003;
   localparam logic [9:0]  LOW_MAX  = 10'h3F2;
   localparam logic [9:0]  HIGH_MIN = 10'h00D;
   localparam logic [9:0]  HIGH_MAX = 10'h3FC;

   // Rate-optimised threshold pairs for dynamic mode
   localparam logic [9:0] DYN_LOW_1G    = 10'h003;
   localparam logic [9:0] DYN_HIGH_1G   = 10'h00D;
   localparam logic [9:0] DYN_LOW_100M  = 10'h005;
   localparam logic [9:0] DYN_HIGH_100M = 10'h00F;
   localparam logic [9:0] DYN_LOW_10M   = 10'h020;
   localparam logic [9:0] DYN_HIGH_10M  = 10'h02A;

   // Storage depths
   localparam int CTC_DEPTH   = 1024;
   localparam int SHALLOW_LIM = 8;

   // Port clock frequencies and derived pacing in hclk cycles
   localparam int HCLK_KHZ     = 25000;
   localparam int PORT_KHZ_1G  = 125000;
   localparam int PORT_KHZ_100 = 25000;
   localparam int PORT_KHZ_10  = 2500;
   localparam int BYTE_1G  = 1;
   localparam int BYTE_100 = 10;
   localparam int BYTE_10  = 100;

   // Idle code-group value that may be dropped or repeated
   localparam logic [7:0] IDLE_CODE = 8'hBC;
endpackage
`default_nettype wire

/* File: rtl/ctc_ram.sv */
`default_nettype none
module ctc_ram
   import ctc_pkg::*;
#(
   parameter int W = 9,
   parameter int D = 1024,
   parameter int A = $clog2(D)
) (
   input  wire logic         clk,
   input  wire logic         we,
   input  wire logic [A-1:0] waddr,
   input  wire logic [W-1:0] wdata,
   input  wire logic [A-1:0] raddr,
   output logic      [W-1:0] rdata
);
   logic [W-1:0] mem [D];

   // Write port
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read data
   always_ff @(posedge clk) begin
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

/* File: rtl/stream_fifo.sv */
`default_nettype none
module stream_fifo
   import ctc_pkg::*;
#(
   parameter int W = 9,
   parameter int D = 8,
   parameter int A = $clog2(D)
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   logic [W-1:0] mem [D];
   logic [A:0]   wptr_reg;
   logic [A:0]   rptr_reg;
   logic         push;
   logic         pop;

   // Full and empty from pointer compare
   assign in_ready  = (wptr_reg - rptr_reg) != (A+1)'(D);
   assign out_valid = wptr_reg != rptr_reg;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rptr_reg[A-1:0]];

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr_reg[A-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
      end else begin
         if (push) wptr_reg <= wptr_reg + 1'b1;
         if (pop)  rptr_reg <= rptr_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/rx_ctc_fifo_gmii_port_config.sv */
// Function
// - Classic style: eight data bits at gigabit
// - Classic 100/10: low nibble only, upper zero
// - Classic style: port clock paced per rate
// - Single-clock style: eight bits every rate
// - Single-clock style: clock enable paces transfers
// - Dynamic mode: rate-selected threshold pair
// - Static mode: configured thresholds stay fixed
// - None mode: shallow crossing, no compensation
// - Low threshold 3..1010, default 16
// - High threshold 13..1020, default 32
// - Compensation storage limited to 1024 entries
`default_nettype none
module rx_ctc_fifo_gmii_port_config
   import ctc_pkg::*;
#(
   parameter int DEPTH     = CTC_DEPTH,
   parameter int BUF_DEPTH = 8
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        link_clk,
   input  wire logic [7:0]  link_data,
   input  wire logic        link_k,
   output logic      [7:0]  rxd,
   output logic             rx_dv,
   output logic             rx_data_en,
   output logic             rx_port_clk
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_L   = (AW+1)'(DEPTH);
   localparam logic [AW:0] SHALLOW_L = (AW+1)'(SHALLOW_LIM);

   // Control and status state
   logic [31:0] ctrl_reg;
   logic [9:0]  low_reg;
   logic [9:0]  high_reg;
   logic        ovf_reg;
   logic [15:0] del_cnt_reg;
   logic [15:0] ins_cnt_reg;
   logic [9:0]  act_low_reg;
   logic [9:0]  act_high_reg;
   logic [9:0]  act_low_next;
   logic [9:0]  act_high_next;
   logic [1:0]  mode;
   logic        style;
   logic [1:0]  rate;
   logic        enable;

   assign mode   = ctrl_reg[CTRL_MODE_LSB +: 2];
   assign style  = ctrl_reg[CTRL_STYLE];
   assign rate   = ctrl_reg[CTRL_RATE_LSB +: 2];
   assign enable = ctrl_reg[CTRL_ENABLE];

   // Clamp a written threshold into its legal range
   function automatic logic [9:0] clamp(input logic [9:0] v,
                                        input logic [9:0] lo,
                                        input logic [9:0] hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction

   // AHB-Lite address phase capture
   logic        wr_pend_reg;
   logic [11:0] wr_addr_reg;
   logic        acc;

   assign acc       = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
      end else begin
         wr_pend_reg <= acc && hwrite;
         if (acc) wr_addr_reg <= haddr[11:0];
      end
   end

   // Link pin synchronisers and edge detect
   logic       lclk_s1;
   logic       lclk_s2;
   logic       lclk_s3;
   cg_t        ldat_s1;
   cg_t        ldat_s2;
   logic       link_edge;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lclk_s1 <= 1'b0;
         lclk_s2 <= 1'b0;
         lclk_s3 <= 1'b0;
         ldat_s1 <= '0;
         ldat_s2 <= '0;
      end else begin
         lclk_s1 <= link_clk;
         lclk_s2 <= lclk_s1;
         lclk_s3 <= lclk_s2;
         ldat_s1 <= '{k: link_k, d: link_data};
         ldat_s2 <= ldat_s1;
      end
   end
   assign link_edge = lclk_s2 && !lclk_s3;

   // Compensation storage pointers and fill
   logic [AW:0] wptr_reg;
   logic [AW:0] rptr_reg;
   logic [AW:0] fill;
   logic [AW:0] full_lvl;
   logic        comp_on;
   logic        in_idle;
   logic        del_now;
   logic        wr_en;
   logic        ovf_set;
   cg_t         ram_q;

   assign fill     = wptr_reg - rptr_reg;
   assign comp_on  = mode != MODE_NONE;
   assign full_lvl = comp_on ? DEPTH_L : SHALLOW_L;
   assign in_idle  = ldat_s2.k && ldat_s2.d == IDLE_CODE;
   assign del_now  = link_edge && enable && comp_on && in_idle
                     && fill > (AW+1)'(act_high_reg);
   assign wr_en    = link_edge && enable && !del_now && fill < full_lvl;
   assign ovf_set  = link_edge && enable && !del_now && fill >= full_lvl;

   ctc_ram #(
      .W (CG_W),
      .D (DEPTH)
   ) u_ram (
      .clk   (hclk),
      .we    (wr_en),
      .waddr (wptr_reg[AW-1:0]),
      .wdata (ldat_s2),
      .raddr (rptr_reg[AW-1:0]),
      .rdata (ram_q)
   );

   // Threshold selection per mode and rate
   always_comb begin
      act_low_next  = low_reg;
      act_high_next = high_reg;
      if (mode == MODE_DYNAMIC) begin
         case (rate)
            RATE_1G: begin
               act_low_next  = DYN_LOW_1G;
               act_high_next = DYN_HIGH_1G;
            end
            RATE_100M: begin
               act_low_next  = DYN_LOW_100M;
               act_high_next = DYN_HIGH_100M;
            end
            default: begin
               act_low_next  = DYN_LOW_10M;
               act_high_next = DYN_HIGH_10M;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_low_reg  <= LOW_RST;
         act_high_reg <= HIGH_RST;
      end else begin
         act_low_reg  <= act_low_next;
         act_high_reg <= act_high_next;
      end
   end

   // Read side: one word staged out of storage
   logic rd_pend_reg;
   logic stage_vld_reg;
   cg_t  stage_reg;
   logic buf_ready;
   logic stage_idle;
   logic ins_now;
   logic stage_take;
   logic rd_issue;

   assign stage_idle = stage_reg.k && stage_reg.d == IDLE_CODE;
   assign ins_now    = stage_vld_reg && buf_ready && comp_on && stage_idle
                       && fill < (AW+1)'(act_low_reg);
   assign stage_take = stage_vld_reg && buf_ready && !ins_now;
   assign rd_issue   = !rd_pend_reg && fill != '0
                       && (!stage_vld_reg || stage_take);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wptr_reg      <= '0;
         rptr_reg      <= '0;
         rd_pend_reg   <= 1'b0;
         stage_vld_reg <= 1'b0;
         stage_reg     <= '0;
      end else begin
         if (wr_en)    wptr_reg <= wptr_reg + 1'b1;
         if (rd_issue) rptr_reg <= rptr_reg + 1'b1;
         rd_pend_reg <= rd_issue;
         if (rd_pend_reg) begin
            stage_reg     <= ram_q;
            stage_vld_reg <= 1'b1;
         end else if (stage_take) begin
            stage_vld_reg <= 1'b0;
         end
      end
   end

   // Buffer toward the MAC side
   logic buf_vld;
   logic buf_pop;
   cg_t  buf_q;

   stream_fifo #(
      .W (CG_W),
      .D (BUF_DEPTH)
   ) u_buf (
      .clk       (hclk),
      .rst_n     (hresetn),
      .in_valid  (stage_vld_reg),
      .in_ready  (buf_ready),
      .in_data   (stage_reg),
      .out_valid (buf_vld),
      .out_ready (buf_pop),
      .out_data  (buf_q)
   );

   // Transfer pacing per style and rate
   logic [7:0] pace_reg;
   logic [7:0] interval;
   logic       nib_mode;
   logic       tick;
   logic       nib_hi_reg;
   logic [3:0] hi_nib_reg;
   logic       hi_dv_reg;

   assign nib_mode = style == STYLE_CLASSIC && rate != RATE_1G;
   always_comb begin
      interval = 8'(BYTE_1G);
      if (rate == RATE_100M) begin
         interval = 8'(BYTE_100);
      end else if (rate == RATE_10M) begin
         interval = 8'(BYTE_10);
      end
      if (nib_mode) begin
         interval = interval >> 1;
      end
   end
   // Leftover count from a slower rate ticks at once
   assign tick    = pace_reg == 8'h00 || pace_reg >= interval;
   assign buf_pop = tick && buf_vld && !(nib_mode && nib_hi_reg);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pace_reg <= 8'h00;
      end else if (tick) begin
         pace_reg <= interval - 8'h01;
      end else begin
         pace_reg <= pace_reg - 8'h01;
      end
   end

   // MAC-side data, valid, enable and port clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rxd         <= 8'h00;
         rx_dv       <= 1'b0;
         rx_data_en  <= 1'b0;
         rx_port_clk <= 1'b0;
         nib_hi_reg  <= 1'b0;
         hi_nib_reg  <= 4'h0;
         hi_dv_reg   <= 1'b0;
      end else begin
         rx_data_en <= tick && style == STYLE_SINGLE;
         if (tick && style == STYLE_CLASSIC) begin
            rx_port_clk <= !rx_port_clk;
         end
         if (tick) begin
            if (nib_mode && nib_hi_reg) begin
               rxd        <= {4'h0, hi_nib_reg};
               rx_dv      <= hi_dv_reg;
               nib_hi_reg <= 1'b0;
            end else if (buf_vld) begin
               rx_dv <= !buf_q.k;
               if (nib_mode) begin
                  rxd        <= {4'h0, buf_q.d[3:0]};
                  hi_nib_reg <= buf_q.d[7:4];
                  hi_dv_reg  <= !buf_q.k;
                  nib_hi_reg <= 1'b1;
               end else begin
                  rxd <= buf_q.d;
               end
            end else begin
               rxd   <= 8'h00;
               rx_dv <= 1'b0;
            end
         end
      end
   end

   // Software registers with clamped thresholds
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RST;
         low_reg  <= LOW_RST;
         high_reg <= HIGH_RST;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == CTRL_OFS) begin
            ctrl_reg <= hwdata & 32'h0000_0137;
         end else if (wr_addr_reg == THRESH_OFS) begin
            low_reg  <= clamp(hwdata[9:0], LOW_MIN, LOW_MAX);
            high_reg <= clamp(hwdata[THR_HIGH_LSB +: 10],
                              HIGH_MIN, HIGH_MAX);
         end
      end
   end

   // Sticky overflow, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_reg <= 1'b0;
      end else if (ovf_set) begin
         ovf_reg <= 1'b1;
      end else if (wr_pend_reg && wr_addr_reg == STATUS_OFS
                   && hwdata[STAT_OVF]) begin
         ovf_reg <= 1'b0;
      end
   end

   // Deleted and inserted idle counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         del_cnt_reg <= 16'h0000;
         ins_cnt_reg <= 16'h0000;
      end else begin
         if (del_now) del_cnt_reg <= del_cnt_reg + 16'h0001;
         if (ins_now) ins_cnt_reg <= ins_cnt_reg + 16'h0001;
      end
   end

   // Read data loaded in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (acc && !hwrite) begin
         if (haddr[11:0] == CTRL_OFS) begin
            hrdata <= ctrl_reg;
         end else if (haddr[11:0] == THRESH_OFS) begin
            hrdata <= {6'h00, high_reg, 6'h00, low_reg};
         end else if (haddr[11:0] == STATUS_OFS) begin
            hrdata <= {15'h0000, ovf_reg, (16-AW-1)'(0), fill};
         end else if (haddr[11:0] == ACTIVE_OFS) begin
            hrdata <= {6'h00, act_high_reg, 6'h00, act_low_reg};
         end else if (haddr[11:0] == COUNT_OFS) begin
            hrdata <= {ins_cnt_reg, del_cnt_reg};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/ctc_chk.sv */
`default_nettype none
module ctc_chk
   import ctc_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic [7:0]  rxd,
   input wire logic        rx_dv,
   input wire logic        rx_data_en,
   input wire logic        rx_port_clk
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic        rd_go;
   logic        wr_ctl_reg;
   logic        style_reg;
   logic [1:0]  rate_reg;
   logic [11:0] a;
   // Read request decode
   assign a = haddr[11:0];
   assign rd_go = hsel && hready && htrans[1] && !hwrite;
   // Mirror of the written port style and rate
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ctl_reg <= 1'b0;
         style_reg  <= STYLE_CLASSIC;
         rate_reg   <= RATE_1G;
      end else begin
         wr_ctl_reg <= hsel && hready && htrans[1] && hwrite && a == CTRL_OFS;
         if (wr_ctl_reg) begin
            style_reg <= hwdata[CTRL_STYLE];
            rate_reg  <= hwdata[CTRL_RATE_LSB +: 2];
         end
      end
   end
   property p_thr_lo;
      rd_go && a == THRESH_OFS |=> hrdata[9:0] inside {[LOW_MIN:LOW_MAX]};
   endproperty
   a_thr_lo: assert property (p_thr_lo) else $error("low range");
   property p_thr_hi;
      rd_go && a == THRESH_OFS |=> hrdata[25:16] inside {[HIGH_MIN:HIGH_MAX]};
   endproperty
   a_thr_hi: assert property (p_thr_hi) else $error("high range");
   property p_act_lo;
      rd_go && a == ACTIVE_OFS |=> hrdata[9:0] >= LOW_MIN;
   endproperty
   a_act_lo: assert property (p_act_lo) else $error("active low bad");
   property p_act_hi;
      rd_go && a == ACTIVE_OFS
         |=> hrdata[25:16] inside {[HIGH_MIN:HIGH_MAX]};
   endproperty
   a_act_hi: assert property (p_act_hi) else $error("act high bad");
   property p_fill;
      rd_go && a == STATUS_OFS |=> hrdata[10:0] <= 11'h400;
   endproperty
   a_fill: assert property (p_fill) else $error("fill above depth");
   property p_rate;
      rd_go && a == CTRL_OFS |=> hrdata[5:4] != 2'h3;
   endproperty
   a_rate: assert property (p_rate) else $error("bad rate code");
   property p_nib;
      style_reg == STYLE_CLASSIC && rate_reg != RATE_1G && rx_dv
         |-> rxd[7:4] == 4'h0;
   endproperty
   a_nib: assert property (p_nib) else $error("upper nibble set");
   property p_one_clk;
      (style_reg == STYLE_SINGLE) [*3] |-> $stable(rx_port_clk);
   endproperty
   a_one_clk: assert property (p_one_clk) else $error("clock moved");
   property p_no_en;
      (style_reg == STYLE_CLASSIC) [*3] |-> !rx_data_en;
   endproperty
   a_no_en: assert property (p_no_en) else $error("classic enable");
   property p_gig_clk;
      (style_reg == STYLE_CLASSIC && rate_reg == RATE_1G) [*4]
         |-> $changed(rx_port_clk);
   endproperty
   a_gig_clk: assert property (p_gig_clk) else $error("clock idle");
   property p_en_pulse;
      style_reg == STYLE_SINGLE && rate_reg != RATE_1G && rx_data_en
         |=> !rx_data_en;
   endproperty
   a_en_pulse: assert property (p_en_pulse) else $error("long en");
   c_nib: cover property (rx_dv && rate_reg == RATE_10M);
   c_single: cover property (rx_data_en && rx_dv);
   c_status: cover property (rd_go && a == STATUS_OFS);
endmodule
bind rx_ctc_fifo_gmii_port_config ctc_chk u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .rxd(rxd), .rx_dv(rx_dv), .rx_data_en(rx_data_en),
   .rx_port_clk(rx_port_clk));
`default_nettype wire

/* File: tb/mac_rx.sv */
`default_nettype none
module mac_rx
   import ctc_pkg::*;
(
   input wire logic       clk,
   input wire logic       style,
   input wire logic [1:0] rate,
   input wire logic [7:0] rxd,
   input wire logic       rx_dv,
   input wire logic       rx_data_en,
   input wire logic       rx_port_clk
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] q[$];
   logic [3:0] lo_nib;
   logic       pclk_q, half, dv_q, tick, nib;
   int         bad, now_c, last, span;
   task automatic clr();
      q.delete();
      bad  = 0;
      half = 0;
      dv_q = 0;
   endtask
   // Transfer tick and expected spacing per style and rate
   assign tick = style ? rx_data_en : (rx_port_clk != pclk_q);
   assign nib  = style == STYLE_CLASSIC && rate != RATE_1G;
   assign span = rate == RATE_100M ? (nib ? BYTE_100 / 2 : BYTE_100)
                 : (nib ? BYTE_10 / 2 : BYTE_10);
   // Collects bytes, low nibble first at the slow classic rates
   always @(posedge clk) begin
      now_c++;
      pclk_q <= rx_port_clk;
      if (tick) begin
         if (rx_dv && dv_q && rate != RATE_1G && now_c - last != span)
            bad++;
         dv_q = rx_dv;
         last = now_c;
         if (rx_dv && nib) begin
            if (rxd[7:4] !== 4'h0)
               bad++;
            if (half)
               q.push_back({rxd[3:0], lo_nib});
            lo_nib = rxd[3:0];
            half   = !half;
         end else if (rx_dv)
            q.push_back(rxd);
      end
   end
   initial begin
      pclk_q = 0;
      now_c  = 0;
      clr();
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
module tb
   import ctc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk, hresetn, hsel, hwrite, link_clk, link_k, style;
   logic        hreadyout, hresp, rx_dv, rx_data_en, rx_port_clk;
   logic [1:0]  htrans, rate;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [7:0]  link_data, rxd;
   int          n_fail, samples_checked, cyc;
   logic [1:0]  rl[3] = '{RATE_1G, RATE_100M, RATE_10M};
   logic [9:0]  dl[3] = '{DYN_LOW_1G, DYN_LOW_100M, DYN_LOW_10M};
   logic [9:0]  dh[3] = '{DYN_HIGH_1G, DYN_HIGH_100M, DYN_HIGH_10M};
   logic [7:0]  pat[4] = '{8'hA5, 8'h3C, 8'hF0, 8'h0F};
   rx_ctc_fifo_gmii_port_config #(.DEPTH(CTC_DEPTH), .BUF_DEPTH(8)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .link_clk(link_clk), .link_data(link_data),
      .link_k(link_k), .rxd(rxd), .rx_dv(rx_dv), .rx_data_en(rx_data_en),
      .rx_port_clk(rx_port_clk));
   mac_rx u_mac (.clk(hclk), .style(style), .rate(rate), .rxd(rxd),
      .rx_dv(rx_dv), .rx_data_en(rx_data_en), .rx_port_clk(rx_port_clk));
   always #20 hclk = ~hclk;
   // Hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic ctl(input logic [1:0] m, input logic s, input logic [1:0] r);
      ahb(1'b1, CTRL_OFS, {23'h0, 1'b1, 2'h0, r, 1'b0, s, m});
      style = s;
      rate  = r;
   endtask
   task automatic rst();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
   endtask
   // One code-group per 320 ns link clock period
   task automatic send(input logic k, input logic [7:0] d);
      @(posedge hclk);
      link_clk  <= 1'b0;
      link_data <= d;
      link_k    <= k;
      repeat (4) @(posedge hclk);
      link_clk  <= 1'b1;
      repeat (3) @(posedge hclk);
   endtask
   task automatic link_off();
      @(posedge hclk);
      link_clk  <= 1'b0;
      link_data <= ~link_data;
   endtask
   function automatic logic [31:0] thr(input logic [9:0] l,
                                       input logic [9:0] h);
      return {6'h0, h, 6'h0, l};
   endfunction
   initial begin
      {hclk, hresetn, hsel, hwrite, link_clk, link_k} = 6'h00;
      {htrans, haddr, hwdata, link_data} = 74'h0;
      {n_fail, samples_checked, cyc} = 0;
      style = STYLE_CLASSIC;
      rate  = RATE_1G;
      rst();
      ahb(1'b0, CTRL_OFS, 0);
      chk(rdv, CTRL_RST);
      ahb(1'b0, THRESH_OFS, 0);
      chk(rdv, thr(LOW_RST, HIGH_RST));
      ahb(1'b0, 12'h020, 0);
      chk(rdv, 32'h0);
      for (int i = 0; i < 3; i++) begin
         ctl(MODE_DYNAMIC, STYLE_CLASSIC, rl[i]);
         ahb(1'b0, ACTIVE_OFS, 0);
         chk(rdv, thr(dl[i], dh[i]));
      end
      ahb(1'b1, THRESH_OFS, 0);
      ahb(1'b0, THRESH_OFS, 0);
      chk(rdv, thr(LOW_MIN, HIGH_MIN));
      ahb(1'b1, THRESH_OFS, 32'hFFFF_FFFF);
      ahb(1'b0, THRESH_OFS, 0);
      chk(rdv, thr(LOW_MAX, HIGH_MAX));
      ahb(1'b1, THRESH_OFS, thr(10'h014, 10'h028));
      for (int i = 0; i < 3; i++) begin
         ctl(MODE_STATIC, STYLE_CLASSIC, rl[i]);
         ahb(1'b0, ACTIVE_OFS, 0);
         chk(rdv, thr(10'h014, 10'h028));
      end
      for (int i = 0; i < 6; i++) begin
         ctl(MODE_DYNAMIC, 1'(i % 2), rl[i / 2]);
         u_mac.clr();
         foreach (pat[j])
            send(1'b0, pat[j]);
         link_off();
         for (int t = 0; t < 1500 && u_mac.q.size() < 4; t++)
            @(posedge hclk);
         foreach (pat[j])
            chk({24'h0, u_mac.q[j]}, {24'h0, pat[j]});
         chk(u_mac.bad, 0);
      end
      ctl(MODE_DYNAMIC, STYLE_CLASSIC, RATE_1G);
      repeat (3) send(1'b1, IDLE_CODE);
      link_off();
      repeat (50) @(posedge hclk);
      ahb(1'b0, COUNT_OFS, 0);
      chk({31'h0, rdv[31:16] != 16'h0}, 1);
      rst();
      ctl(MODE_DYNAMIC, STYLE_SINGLE, RATE_10M);
      repeat (80) send(1'b1, IDLE_CODE);
      link_off();
      ahb(1'b0, COUNT_OFS, 0);
      chk({31'h0, rdv[15:0] != 16'h0}, 1);
      ahb(1'b0, STATUS_OFS, 0);
      chk({31'h0, rdv[STAT_OVF]}, 0);
      rst();
      ahb(1'b0, CTRL_OFS, 0);
      chk(rdv, CTRL_RST);
      ctl(MODE_NONE, STYLE_SINGLE, RATE_10M);
      for (int j = 0; j < 30; j++)
         send(1'b0, 8'(j));
      link_off();
      ahb(1'b0, STATUS_OFS, 0);
      chk({31'h0, rdv[STAT_OVF]}, 1);
      repeat (2500) @(posedge hclk);
      ahb(1'b1, STATUS_OFS, 32'h0001_0000);
      ahb(1'b0, STATUS_OFS, 0);
      chk({31'h0, rdv[STAT_OVF]}, 0);
      ahb(1'b1, CTRL_OFS, {29'h0, STYLE_SINGLE, MODE_NONE});
      repeat (12) send(1'b0, 8'h5A);
      ahb(1'b0, STATUS_OFS, 0);
      chk(rdv, 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
